// ---- common/fso_pkg.sv ----
// ----------------------------------------
// register map, fields, resets, timing
// ----------------------------------------
package fso_pkg;
    localparam logic [7:0] A_DO = 8'h00;
    localparam logic [7:0] A_KIND = 8'h04;
    localparam logic [7:0] A_PAT = 8'h08;
    localparam logic [7:0] A_DLY = 8'h0C;
    localparam logic [7:0] A_COMMIT = 8'h10;
    localparam logic [7:0] A_STAT = 8'h14;
    localparam logic [7:0] A_PT_BASE = 8'h20;
    localparam logic [7:0] A_PB_BASE = 8'h30;
    localparam int NPTS = 4;
    localparam int COMMIT_BIT = 0;
    localparam int S_COMM = 0;
    localparam int S_WAIT = 1;
    localparam int S_SAFE = 2;
    localparam int S_KIND = 8;
    localparam logic [7:0] K_OFF = 8'h01;
    localparam logic [7:0] K_PAT = 8'h02;
    localparam logic [7:0] K_LAST = 8'h03;
    localparam logic [3:0] RST_DO = 4'h0;
    localparam logic [7:0] RST_KIND = 8'h01;
    localparam logic [3:0] RST_PAT = 4'h0;
    localparam logic [7:0] RST_DLY = 8'h00;
    localparam int CLK_NS = 40;
    localparam int TENTH_NS = 100000000;
    localparam int TENTH_CYC = TENTH_NS / CLK_NS;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_WAIT = 3'b010,
        ST_SAFE = 3'b100
    } fso_state_t;
endpackage : fso_pkg

// ---- common/fso_tmr_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// link between control fsm and delay timer
// ----------------------------------------
interface fso_tmr_if;
    logic start;
    logic cancel;
    logic [7:0] delay;
    logic expired;
    modport ctl (output start, output cancel, output delay, input expired);
    modport tmr (input start, input cancel, input delay, output expired);
endinterface : fso_tmr_if
`default_nettype wire

// ---- src/fso_delay_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module fso_delay_timer #(
    parameter int unsigned P_TENTH_CYC = fso_pkg::TENTH_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    fso_tmr_if.tmr tif
);
    localparam int PW = $clog2(P_TENTH_CYC + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(P_TENTH_CYC - 1);
    logic [PW-1:0] pre;
    logic [PW-1:0] next_pre;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic run;
    logic next_run;
    logic next_exp;

    // ----------------------------------------
    // tenth-second prescaler and delay count
    // ----------------------------------------
    always_comb begin
        next_pre = pre;
        next_cnt = cnt;
        next_run = run;
        next_exp = 1'b0;
        if (tif.cancel) begin
            next_run = 1'b0;
        end else if (tif.start) begin
            next_run = 1'b1;
            next_cnt = tif.delay;
            next_pre = '0;
        end else if (run) begin
            if (pre == PRE_LAST) begin
                next_pre = '0;
                // a count of one or less ends on this tenth
                if (cnt <= 8'h01) begin
                    next_run = 1'b0;
                    next_exp = 1'b1;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end else begin
                next_pre = pre + PW'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre <= '0;
            cnt <= 8'h00;
            run <= 1'b0;
            tif.expired <= 1'b0;
        end else if (i_ce) begin
            pre <= next_pre;
            cnt <= next_cnt;
            run <= next_run;
            tif.expired <= next_exp;
        end
    end

    property p_exp_pulse;
        @(posedge i_clk) disable iff (!i_rst_b)
        tif.expired && i_ce |=> !tif.expired;
    endproperty
    a_exp_pulse: assert property (p_exp_pulse)
        else $error("expiry longer than one cycle");
endmodule : fso_delay_timer
`default_nettype wire

// ---- src/fso_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fso_top #(
    parameter int unsigned P_TENTH_CYC = fso_pkg::TENTH_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_comm_ok,
    output logic [31:0] o_rdata,
    output logic [3:0] o_points,
    output logic o_failsafe_active
);
    fso_pkg::fso_state_t st;
    fso_pkg::fso_state_t next_st;
    logic [3:0] host_out;
    logic [3:0] next_host;
    logic [7:0] stg_kind;
    logic [7:0] next_stg_kind;
    logic [3:0] stg_pat;
    logic [3:0] next_stg_pat;
    logic [7:0] stg_dly;
    logic [7:0] next_stg_dly;
    logic commit_flag;
    logic next_commit;
    logic [7:0] act_kind;
    logic [7:0] next_act_kind;
    logic [3:0] act_pat;
    logic [3:0] next_act_pat;
    logic [7:0] act_dly;
    logic [7:0] next_act_dly;
    logic [3:0] next_points;
    logic next_fs_active;
    logic [31:0] next_rdata;
    logic [31:0] stat;
    logic [3:0] pt_we;
    logic [3:0] pb_we;
    logic [3:0] host_bits;
    logic [3:0] pat_bits;
    logic we_do;
    logic we_commit;
    logic host_wr;

    fso_tmr_if tif ();

    fso_delay_timer #(
        .P_TENTH_CYC(P_TENTH_CYC)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .tif(tif.tmr)
    );

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    assign we_do = i_wr && (i_addr == fso_pkg::A_DO);
    assign we_commit = i_wr && (i_addr == fso_pkg::A_COMMIT);
    assign host_wr = we_do || (|pt_we);

    for (genvar n = 0; n < fso_pkg::NPTS; n++) begin : g_pt
        assign pt_we[n] = i_wr && (i_addr == fso_pkg::A_PT_BASE + 8'(4 * n));
        assign pb_we[n] = i_wr && (i_addr == fso_pkg::A_PB_BASE + 8'(4 * n));
        assign host_bits[n] = pt_we[n] ? i_wdata[0] : host_out[n];
        assign pat_bits[n] = pb_we[n] ? i_wdata[0] : stg_pat[n];
    end

    // ----------------------------------------
    // registers, staging and commit
    // ----------------------------------------
    always_comb begin
        next_host = host_bits;
        next_stg_kind = stg_kind;
        next_stg_pat = pat_bits;
        next_stg_dly = stg_dly;
        next_act_kind = act_kind;
        next_act_pat = act_pat;
        next_act_dly = act_dly;
        next_commit = commit_flag;
        if (we_do) begin
            next_host = i_wdata[3:0];
        end
        if (i_wr && (i_addr == fso_pkg::A_KIND)) begin
            next_stg_kind = i_wdata[7:0];
        end
        if (i_wr && (i_addr == fso_pkg::A_PAT)) begin
            next_stg_pat = i_wdata[3:0];
        end
        if (i_wr && (i_addr == fso_pkg::A_DLY)) begin
            next_stg_dly = i_wdata[7:0];
        end
        if (commit_flag) begin
            next_act_kind = stg_kind;
            next_act_pat = stg_pat;
            next_act_dly = stg_dly;
            next_commit = 1'b0;
        end
        // a new commit in the transfer cycle is kept, not lost
        if (we_commit && i_wdata[fso_pkg::COMMIT_BIT]) begin
            next_commit = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            host_out <= fso_pkg::RST_DO;
            stg_kind <= fso_pkg::RST_KIND;
            stg_pat <= fso_pkg::RST_PAT;
            stg_dly <= fso_pkg::RST_DLY;
            act_kind <= fso_pkg::RST_KIND;
            act_pat <= fso_pkg::RST_PAT;
            act_dly <= fso_pkg::RST_DLY;
            commit_flag <= 1'b0;
        end else if (i_ce) begin
            host_out <= next_host;
            stg_kind <= next_stg_kind;
            stg_pat <= next_stg_pat;
            stg_dly <= next_stg_dly;
            act_kind <= next_act_kind;
            act_pat <= next_act_pat;
            act_dly <= next_act_dly;
            commit_flag <= next_commit;
        end
    end

    // ----------------------------------------
    // fail-safe state machine and point drive
    // ----------------------------------------
    assign tif.delay = act_dly;

    always_comb begin
        next_st = st;
        tif.start = 1'b0;
        tif.cancel = 1'b0;
        unique case (st)
            fso_pkg::ST_RUN: begin
                if (!i_comm_ok) begin
                    if (act_dly == 8'h00) begin
                        next_st = fso_pkg::ST_SAFE;
                    end else begin
                        tif.start = 1'b1;
                        next_st = fso_pkg::ST_WAIT;
                    end
                end
            end
            fso_pkg::ST_WAIT: begin
                if (i_comm_ok) begin
                    tif.cancel = 1'b1;
                    next_st = fso_pkg::ST_RUN;
                end else if (tif.expired) begin
                    next_st = fso_pkg::ST_SAFE;
                end
            end
            fso_pkg::ST_SAFE: begin
                // only a fresh output write proves the host is back in control
                if (i_comm_ok && host_wr) begin
                    next_st = fso_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_comb begin
        next_points = host_out;
        if (st == fso_pkg::ST_SAFE) begin
            case (act_kind)
                fso_pkg::K_OFF: next_points = 4'h0;
                fso_pkg::K_PAT: next_points = act_pat;
                fso_pkg::K_LAST: next_points = o_points;
                // unknown kinds fall back to the safest state
                default: next_points = 4'h0;
            endcase
        end
        next_fs_active = (next_st == fso_pkg::ST_SAFE);
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= fso_pkg::ST_RUN;
            o_points <= fso_pkg::RST_DO;
            o_failsafe_active <= 1'b0;
        end else if (i_ce) begin
            st <= next_st;
            o_points <= next_points;
            o_failsafe_active <= next_fs_active;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_comb begin
        stat = 32'h0000_0000;
        stat[fso_pkg::S_COMM] = i_comm_ok;
        stat[fso_pkg::S_WAIT] = (st == fso_pkg::ST_WAIT);
        stat[fso_pkg::S_SAFE] = (st == fso_pkg::ST_SAFE);
        stat[fso_pkg::S_KIND +: 8] = act_kind;
        next_rdata = 32'h0000_0000;
        if (i_rd) begin
            if (i_addr == fso_pkg::A_DO) begin
                next_rdata = {28'h000_0000, host_out};
            end else if (i_addr == fso_pkg::A_STAT) begin
                next_rdata = stat;
            end else if ((i_addr[7:4] == fso_pkg::A_PT_BASE[7:4]) && (i_addr[1:0] == 2'h0)) begin
                next_rdata = {31'h0000_0000, host_out[i_addr[3:2]]};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_ce) begin
            o_rdata <= next_rdata;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_off;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st == fso_pkg::ST_SAFE) && i_ce && (act_kind == fso_pkg::K_OFF) |=> o_points == 4'h0;
    endproperty
    a_off: assert property (p_off)
        else $error("kind off did not clear points");

    property p_pat;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st == fso_pkg::ST_SAFE) && i_ce && (act_kind == fso_pkg::K_PAT)
            |=> o_points == $past(act_pat);
    endproperty
    a_pat: assert property (p_pat)
        else $error("pattern not driven on points");

    property p_last;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st == fso_pkg::ST_SAFE) && i_ce && (act_kind == fso_pkg::K_LAST) |=> $stable(o_points);
    endproperty
    a_last: assert property (p_last)
        else $error("last state not held");

    property p_host_drive;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st != fso_pkg::ST_SAFE) && i_ce |=> o_points == $past(host_out);
    endproperty
    a_host_drive: assert property (p_host_drive)
        else $error("host value not driven outside fail-safe");

    property p_commit_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
        commit_flag && i_ce && !we_commit |=> !commit_flag;
    endproperty
    a_commit_clear: assert property (p_commit_clear)
        else $error("commit flag did not clear");

    property p_transfer;
        @(posedge i_clk) disable iff (!i_rst_b)
        commit_flag && i_ce |=> (act_kind == $past(stg_kind)) && (act_dly == $past(stg_dly));
    endproperty
    a_transfer: assert property (p_transfer)
        else $error("staged config not transferred");

    property p_staged_hold;
        @(posedge i_clk) disable iff (!i_rst_b)
        !commit_flag |=> $stable(act_kind) && $stable(act_pat) && $stable(act_dly);
    endproperty
    a_staged_hold: assert property (p_staged_hold)
        else $error("active config changed without commit");

    property p_commit_zero;
        @(posedge i_clk) disable iff (!i_rst_b)
        we_commit && !i_wdata[fso_pkg::COMMIT_BIT] && !commit_flag |=> !commit_flag;
    endproperty
    a_commit_zero: assert property (p_commit_zero)
        else $error("commit zero caused action");

    property p_zero_delay;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st == fso_pkg::ST_RUN) && !i_comm_ok && (act_dly == 8'h00) && i_ce
            |=> (st == fso_pkg::ST_SAFE) && o_failsafe_active;
    endproperty
    a_zero_delay: assert property (p_zero_delay)
        else $error("zero delay did not enter fail-safe");

    property p_cancel;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st == fso_pkg::ST_WAIT) && i_comm_ok && i_ce |=> st == fso_pkg::ST_RUN;
    endproperty
    a_cancel: assert property (p_cancel)
        else $error("restored link did not cancel entry");

    property p_resume;
        @(posedge i_clk) disable iff (!i_rst_b)
        (st == fso_pkg::ST_SAFE) && i_comm_ok && we_do && i_ce ##1 i_ce
            |=> o_points == $past(i_wdata[3:0], 2);
    endproperty
    a_resume: assert property (p_resume)
        else $error("host write did not resume outputs");

    property p_trunc;
        @(posedge i_clk) disable iff (!i_rst_b)
        we_do && i_ce |=> host_out == $past(i_wdata[3:0]);
    endproperty
    a_trunc: assert property (p_trunc)
        else $error("packed write not cropped to four bits");
endmodule : fso_top
`default_nettype wire

// ---- verif/fso_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side of the supervisory link
// ----------------------------------------
// the host only reports link health as a level; it changes on a clock edge
// because the device expects a signal synchronous to its own clock
module fso_link_model (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_link_up,
    output logic o_comm_ok
);
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_comm_ok <= 1'b1;
        end else begin
            o_comm_ok <= i_link_up;
        end
    end
endmodule : fso_link_model
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TC = 4;
    logic clk, rst_b, ce, wr, rd, link_req, comm_ok, fs, rd_seen;
    logic [7:0] addr, kk;
    logic [31:0] wdata, rdata, w, w2;
    logic [3:0] pts, pv, hv, ev;
    logic [31:0] expq[$];
    int fail_count, checks_done, seed, n, k, i;

    fso_top #(.P_TENTH_CYC(TC)) uut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_comm_ok(comm_ok),
        .o_rdata(rdata), .o_points(pts), .o_failsafe_active(fs));
    fso_link_model link (.i_clk(clk), .i_rst_b(rst_b), .i_link_up(link_req),
        .o_comm_ok(comm_ok));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp_pts(input logic [3:0] exp);
        cmp({28'h0, pts}, {28'h0, exp});
    endtask : cmp_pts

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask : wr_reg

    // the expectation is queued before the strobe so the monitor never runs dry
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        rd <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        @(posedge clk);
    endtask : rd_reg

    task automatic idle(input int cyc);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (cyc) @(posedge clk);
        #1;
    endtask : idle

    // drop the link and count edges from comm_ok falling to fail-safe entry
    task automatic enter(output int cnt);
        wr <= 1'b0;
        rd <= 1'b0;
        link_req <= 1'b0;
        cnt = 0;
        while (comm_ok !== 1'b0 && cnt < 10) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        cnt = 0;
        while (fs !== 1'b1 && cnt < 2000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask : enter

    task automatic finish_test;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // read data monitor
    // ----------------------------------------
    always @(posedge clk) begin
        if (rd_seen) begin
            if (expq.size() == 0) begin
                cmp(rdata, 32'hDEAD_BEEF);
            end else begin
                cmp(rdata, expq.pop_front());
            end
        end
        rd_seen <= rd && rst_b;
    end

    initial begin
        #(40 * 20000);
        fail_count++;
        finish_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        link_req = 1'b1;
        rd_seen = 1'b0;
        seed = 31572;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd_reg(fso_pkg::A_DO, 32'h0);
        rd_reg(fso_pkg::A_STAT, 32'h0000_0101);
        rd_reg(fso_pkg::A_KIND, 32'h0);
        rd_reg(8'h50, 32'h0);
        w = $random(seed);
        wr_reg(fso_pkg::A_DO, w);
        wr_reg(8'h50, 32'hFFFF_FFFF);
        wr_reg(fso_pkg::A_STAT, 32'hFFFF_FFFF);
        rd_reg(fso_pkg::A_DO, {28'h0, w[3:0]});
        idle(1);
        cmp_pts(w[3:0]);
        for (i = 0; i < 4; i++) wr_reg(fso_pkg::A_PT_BASE + 8'(4 * i), {31'h0, ~w[i]});
        for (i = 0; i < 4; i++) rd_reg(fso_pkg::A_PT_BASE + 8'(4 * i), {31'h0, ~w[i]});
        rd_reg(fso_pkg::A_STAT, 32'h0000_0101);
        idle(2);
        cmp_pts(~w[3:0]);
        $display("test registers done");
        for (k = 1; k <= 3; k++) begin
            w = $random(seed);
            hv = w[3:0];
            pv = w[7:4];
            kk = 8'(k);
            wr_reg(fso_pkg::A_DO, w);
            wr_reg(fso_pkg::A_PAT, w >> 4);
            wr_reg(fso_pkg::A_DLY, 32'h0);
            wr_reg(fso_pkg::A_KIND, {24'h0, kk});
            wr_reg(fso_pkg::A_COMMIT, 32'h1);
            wr_reg(fso_pkg::A_KIND, {24'h0, 8'(k % 3 + 1)});
            wr_reg(fso_pkg::A_COMMIT, 32'hFFFF_FFFE);
            rd_reg(fso_pkg::A_STAT, {16'h0, kk, 8'h01});
            rd_reg(fso_pkg::A_COMMIT, 32'h0);
            enter(n);
            cmp(32'(n >= 1 && n <= 3), 32'h1);
            idle(2);
            ev = (k == 1) ? 4'h0 : ((k == 2) ? pv : hv);
            cmp_pts(ev);
            wr_reg(fso_pkg::A_DO, {28'h0, ~hv});
            idle(3);
            cmp_pts(ev);
            link_req <= 1'b1;
            idle(3);
            cmp({31'h0, fs}, 32'h1);
            w2 = $random(seed);
            wr_reg(fso_pkg::A_DO, w2);
            idle(3);
            cmp({31'h0, fs}, 32'h0);
            cmp_pts(w2[3:0]);
        end
        $display("test kinds done");
        wr_reg(fso_pkg::A_PAT, 32'h0000_00F5);
        wr_reg(fso_pkg::A_PB_BASE + 8'h08, 32'hFFFF_FFFE);
        wr_reg(fso_pkg::A_DLY, 32'h3);
        wr_reg(fso_pkg::A_KIND, 32'h2);
        wr_reg(fso_pkg::A_COMMIT, 32'h1);
        link_req <= 1'b0;
        idle(5);
        rd_reg(fso_pkg::A_STAT, 32'h0000_0202);
        link_req <= 1'b1;
        idle(6 * TC);
        cmp({31'h0, fs}, 32'h0);
        cmp_pts(w2[3:0]);
        enter(n);
        cmp(32'(n >= 3 * TC && n <= 3 * TC + 5), 32'h1);
        idle(2);
        cmp_pts(4'h1);
        link_req <= 1'b1;
        idle(2);
        wr_reg(fso_pkg::A_DO, 32'h0);
        wr_reg(fso_pkg::A_DLY, 32'hFF);
        wr_reg(fso_pkg::A_COMMIT, 32'h1);
        enter(n);
        cmp(32'(n >= 255 * TC && n <= 255 * TC + 5), 32'h1);
        $display("test delays done");
        // enable low must freeze points and drop the second write
        link_req <= 1'b1;
        idle(2);
        wr_reg(fso_pkg::A_DO, 32'h9);
        ce <= 1'b0;
        wr_reg(fso_pkg::A_DO, 32'h6);
        idle(3);
        cmp_pts(4'h1);
        ce <= 1'b1;
        idle(2);
        cmp_pts(4'h9);
        $display("test enable done");
        idle(3);
        finish_test();
    end
endmodule : testbench
`default_nettype wire
